// ===== sirq_pkg.sv
// package for the serialized interrupt slave: states, slots, timing
`default_nettype none
package sirq_pkg;
	localparam int unsigned SLOT_CNT        = 32;
	localparam int unsigned SLOT_W          = 5;
	localparam int unsigned PHASE_CLKS      = 3;
	localparam int unsigned STOP_QUIET_CLKS = 2;
	localparam int unsigned STOP_CONT_CLKS  = 3;
	localparam int unsigned START_MIN_CLKS  = 4;
	localparam int unsigned LOW_CNT_W       = 4;
	localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = 4'hF;
	localparam logic        MODE_CONT       = 1'b1;
	localparam logic        MODE_QUIET      = 1'b0;

	typedef enum logic [4:0] {
		SQ_IDLE   = 5'h01,
		SQ_START  = 5'h02,
		SQ_FRAMES = 5'h04,
		SQ_STOP   = 5'h08,
		SQ_KICK   = 5'h10
	} sirq_state_e;

	typedef enum logic [2:0] {
		PH_SAMPLE  = 3'h1,
		PH_RECOVER = 3'h2,
		PH_TURN    = 3'h4
	} sirq_phase_e;

	typedef struct packed {
		logic o;
		logic oe;
	} sirq_pin_s;
endpackage
`default_nettype wire

// ===== sirq_slave.sv
// serialized interrupt link, slave end inside the peripheral
// Function
// - shared open-drain line; drive low or high only in owned clocks, else release.
// - cycle is start frame, then data frames, then stop frame.
// - quiet mode: device drives one low clock, then releases.
// - after reset both ends are in continuous mode.
// - frames counted from the rising edge ending the start pulse.
// - each data frame is sample, recovery, turn-around, three clocks.
// - sample phase: drive low if request active, otherwise release.
// - recovery after a low sample drives high; turn-around releases.
// - fixed slot order, slot n sampled 3n+4 clocks after the rising edge ending start.
// - slot driving begins with slot 0, changing on rising clock edges.
// - stop of 2 selects quiet, 3 selects continuous; device measures width.
// - idle clocks may pass between stop and next start.
// - in quiet mode device starts only with a pending request.
`timescale 1ns/100ps
`default_nettype none
module sirq_slave
	import sirq_pkg::*;
#(
	parameter int unsigned SLOTS = SLOT_CNT
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic [SLOTS-1:0]  IRQ_REQ,
	input  wire logic [SLOTS-1:0]  IRQ_OWN,
	input  wire logic              SIRQ_IN,
	output logic                   SIRQ_OUT,
	output logic                   SIRQ_OE,
	output logic                   MODE_CONTINUOUS
);

////////////////////////////////////////////////////////////////////////
// pin synchroniser and line level

	logic        sync1_q;
	logic        line_q;
	logic        line_prev_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_q     <= 1'b1;
			line_q      <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			sync1_q     <= SIRQ_IN;
			line_q      <= sync1_q;
			line_prev_q <= line_q;
		end
	end

	wire rise_seen = line_q & ~line_prev_q;

////////////////////////////////////////////////////////////////////////
// timing notes
// every decision below is made on the synchronised line, so the pin
// view of the device lags the wire by the two synchroniser stages plus
// the registered output stage; the slot grid is still anchored to the
// rising edge that ends the start pulse, so this latency only shifts
// all slots by the same amount and the host sees them in order.
// the slot counter starts one below slot 0 so that the first turn-around
// step lands on slot 0; a separate flag tells that pre-slot apart from
// the real last slot, which shares the same counter value at full width.

////////////////////////////////////////////////////////////////////////
// cycle state

	sirq_state_e          state_q, state_d;
	sirq_phase_e          phase_q, phase_d;
	logic [SLOT_W-1:0]    slot_q, slot_d;
	logic [LOW_CNT_W-1:0] low_q, low_d;
	logic                 mode_q, mode_d;
	logic                 hold_q, hold_d;
	logic                 first_q, first_d;
	sirq_pin_s            pin_q, pin_d;

	// requests are latched per cycle so a slot does not change mid-frame
	logic [SLOTS-1:0]     req_q;
	wire  [SLOTS-1:0]     own_req = IRQ_REQ & IRQ_OWN;
	wire                  any_req = |own_req;
	wire                  last_slot = (slot_q == SLOT_W'(SLOTS - 1));
	wire                  cur_req = req_q[slot_q];
	wire                  low_sat = (low_q == LOW_CNT_MAX);

	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		slot_d  = slot_q;
		low_d   = low_q;
		mode_d  = mode_q;
		hold_d  = hold_q;
		first_d = first_q;
		pin_d   = '{o: 1'b1, oe: 1'b0};
		case (state_q)
			SQ_IDLE: begin
				low_d = '0;
				if (!line_q) begin
					state_d = SQ_START;
				end else if (mode_q == MODE_QUIET && any_req && line_prev_q) begin
					state_d = SQ_KICK;
					pin_d   = '{o: 1'b0, oe: 1'b1};
				end
			end
			SQ_KICK: begin
				// our single low clock is on the pin; release and wait for host
				if (!line_q) begin
					state_d = SQ_START;
				end
			end
			SQ_START: begin
				if (line_q) begin
					// rising edge ends start pulse; next clock is a turn-around step, then slot 0 sample
					state_d = (rise_seen && low_q >= LOW_CNT_W'(START_MIN_CLKS - 2))
						? SQ_FRAMES : SQ_IDLE;
					phase_d = PH_TURN;
					slot_d  = '1;
					first_d = 1'b1;
				end else if (!low_sat) begin
					low_d = low_q + 1'b1;
				end
			end
			SQ_FRAMES: begin
				low_d = '0;
				case (phase_q)
					PH_TURN: begin
						if (!first_q && last_slot) begin
							state_d = SQ_STOP;
						end else begin
							first_d = 1'b0;
							phase_d = PH_SAMPLE;
							slot_d  = slot_q + 1'b1;
							hold_d  = req_q[slot_q + 1'b1];
							if (req_q[slot_q + 1'b1]) begin
								pin_d = '{o: 1'b0, oe: 1'b1};
							end
						end
					end
					PH_SAMPLE: begin
						phase_d = PH_RECOVER;
						if (hold_q) begin
							pin_d = '{o: 1'b1, oe: 1'b1};
						end
					end
					default: begin
						phase_d = PH_TURN;
						hold_d  = 1'b0;
					end
				endcase
			end
			SQ_STOP: begin
				// count low clocks of the host stop pulse
				if (!line_q) begin
					if (!low_sat) begin
						low_d = low_q + 1'b1;
					end
				end else if (low_q != '0) begin
					state_d = SQ_IDLE;
					if (low_q == LOW_CNT_W'(STOP_QUIET_CLKS)) begin
						mode_d = MODE_QUIET;
					end else if (low_q >= LOW_CNT_W'(STOP_CONT_CLKS)) begin
						mode_d = MODE_CONT;
					end
				end
			end
			default: begin
				state_d = SQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= SQ_IDLE;
			phase_q <= PH_TURN;
			slot_q  <= '0;
			low_q   <= '0;
			mode_q  <= MODE_CONT;
			hold_q  <= 1'b0;
			first_q <= 1'b0;
			pin_q   <= '{o: 1'b1, oe: 1'b0};
			req_q   <= '0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			slot_q  <= slot_d;
			low_q   <= low_d;
			mode_q  <= mode_d;
			hold_q  <= hold_d;
			first_q <= first_d;
			pin_q   <= pin_d;
			if (state_q != SQ_FRAMES) begin
				req_q <= own_req;
			end
		end
	end

////////////////////////////////////////////////////////////////////////
// outputs

	// all pin controls come straight from flops, so no glitch reaches
	// the shared wire between clock edges
	assign SIRQ_OUT        = pin_q.o;
	assign SIRQ_OE         = pin_q.oe;
	assign MODE_CONTINUOUS = mode_q;

	wire unused_cur = cur_req;

endmodule // sirq_slave
`default_nettype wire

// ===== sirq_slave_monitor.sv
// assertions on the serial interrupt slave ports
`timescale 1ns/100ps
`default_nettype none
module sirq_slave_monitor
	import sirq_pkg::*;
#(parameter int unsigned SLOTS = SLOT_CNT) (
	input wire logic             CLK,
	input wire logic             RST,
	input wire logic [SLOTS-1:0] IRQ_REQ,
	input wire logic [SLOTS-1:0] IRQ_OWN,
	input wire logic             SIRQ_IN,
	input wire logic             SIRQ_OUT,
	input wire logic             SIRQ_OE,
	input wire logic             MODE_CONTINUOUS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire        lo = SIRQ_OE & !SIRQ_OUT;
	wire        hi = SIRQ_OE & SIRQ_OUT;
	wire        pend = |(IRQ_REQ & IRQ_OWN);
	// saturating counts of a high line and of no owned request
	logic [7:0] hq_q, nq_q;
	always_ff @(posedge CLK) begin
		hq_q <= (RST | !SIRQ_IN) ? 8'h00 : hq_q + {7'h00, hq_q != 8'hFF};
		nq_q <= (RST | pend) ? 8'h00 : nq_q + {7'h00, nq_q != 8'hFF};
	end
	rst_val_a: assert property (disable iff (1'h0) RST |=> !SIRQ_OE)
		else $error("drive in reset");
	gap_a: assert property (lo |=> !lo [*2])
		else $error("low clock repeated");
	high_one_a: assert property (hi |=> !SIRQ_OE)
		else $error("high not released");
	rec_a: assert property (hi |-> $past(lo))
		else $error("high without low");
	cont_kick_a: assert property (MODE_CONTINUOUS && hq_q > 8'h78 |-> !SIRQ_OE)
		else $error("start in continuous");
	mode_hold_a: assert property (hq_q > 8'h08 |-> $stable(MODE_CONTINUOUS))
		else $error("mode moved");
	no_req_a: assert property (nq_q > 8'hC8 |-> !SIRQ_OE)
		else $error("drive without request");
	rel_a: assert property ($fell(RST) |-> MODE_CONTINUOUS [*3])
		else $error("not continuous");
endmodule // sirq_slave_monitor
bind sirq_slave sirq_slave_monitor #(.SLOTS(SLOTS)) i_mon (.CLK(CLK), .RST(RST),
	.IRQ_REQ(IRQ_REQ), .IRQ_OWN(IRQ_OWN), .SIRQ_IN(SIRQ_IN), .SIRQ_OUT(SIRQ_OUT),
	.SIRQ_OE(SIRQ_OE), .MODE_CONTINUOUS(MODE_CONTINUOUS));
`default_nettype wire

// ===== sirq_host.sv
// host end of the serial interrupt line: start, 32 slots, stop
`timescale 1ns/100ps
`default_nettype none
module sirq_host (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [3:0]  sw,
	input  wire logic [1:0]  pw,
	input  wire logic        line,
	output logic             low,
	output logic             busy,
	output logic [31:0]      seen
);
	logic [7:0] c;
	wire  [7:0] r = c - {4'h0, sw};
	// a low line while idle is the slave's start clock: take over at once
	always_ff @(posedge clk) begin
		c <= busy ? c + 8'h01 : 8'h00;
		if (rst) busy <= 1'h0;
		else if (!busy) busy <= go | !line;
		else if (r == 8'h63 + pw) busy <= 1'h0;
		if (!busy) seen <= '0;
		else if (r > 8'h02 && r < 8'h63 && !line)
			seen[(r - 8'h03) / 8'h03] <= 1'h1;
	end
	// the pull-up gives the high clock after the start pulse
	assign low = busy && (c < sw || (r > 8'h62 && r < 8'h63 + pw));
endmodule // sirq_host
`default_nettype wire

// ===== testbench.sv
// self-checking bench: slave and host model on one open-drain line
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value %0t %h %h", $time, a, b); end end
module testbench;
	import sirq_pkg::*;
	logic        CLK = 1'h0, RST = 1'h1, go = 1'h0, oe, out, mode, low, busy;
	logic [31:0] req = '1, own = '1, got, seen, seed = 32'h5779;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	logic [3:0]  sw = 4'h4;
	logic [1:0]  pw = 2'h3;
	int          n_fail = 0, compares = 0;
	wire         line = !((oe & !out) | low);
	always #25 CLK = !CLK;
	sirq_slave i_dut (.CLK(CLK), .RST(RST), .IRQ_REQ(req), .IRQ_OWN(own),
		.SIRQ_IN(line), .SIRQ_OUT(out), .SIRQ_OE(oe), .MODE_CONTINUOUS(mode));
	sirq_host i_host (.clk(CLK), .rst(RST), .go(go), .sw(sw), .pw(pw),
		.line(line), .low(low), .busy(busy), .seen(seen));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic stop_test;
		if (n_fail == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// k: leave the start to the slave; slot 1 is always pending and owned
	task automatic run(input logic [3:0] s, input logic [1:0] p, input logic k);
		seed = lfsr(seed);
		@(posedge CLK);
		req <= seed | 32'h2;
		own <= lfsr(seed) | 32'h2;
		sw <= s;
		pw <= p;
		go <= !k;
		exp_q.push_back({p == 2'h3, (seed | 32'h2) & (lfsr(seed) | 32'h2)});
		@(posedge CLK);
		go <= 1'h0;
		wait (busy);
		wait (!busy);
		req <= '0;
		repeat (8) @(posedge CLK);
	endtask
	task automatic idle_chk;
		repeat (250) @(posedge CLK);
		#1 `CHK(busy, 1'h0)
	endtask
	always @(negedge busy) if (!RST) begin
		got = seen;
		repeat (6) @(posedge CLK);
		e = exp_q.pop_front();
		#1 `CHK({mode, got}, e)
	end
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 1'h0;
		idle_chk;
		`CHK(mode, MODE_CONT)
		for (int i = 0; i < 5; i++) run(4'h4 + 4'(i), 2'h3, 1'h0);
		run(4'h5, 2'h2, 1'h0);
		for (int i = 0; i < 5; i++) run(4'h3 + 4'(i), 2'h2, 1'h1);
		idle_chk;
		@(posedge CLK);
		req <= '1;
		own <= '0;
		idle_chk;
		run(4'h4, 2'h3, 1'h0);
		stop_test;
	end
	initial begin
		repeat (3000) @(posedge CLK);
		n_fail++;
		stop_test;
	end
endmodule // testbench
`default_nettype wire
